// [rsc_regulator_ctrl.sv]
// Ramp timing, forced PWM and linear regulator level registers behind an APB slave.
// Assumes buck setpoints, their update strobes and the unlock flag come from logic on pclk.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
`include "rsc_consts.svh"
module rsc_regulator_ctrl #(
  parameter int DWELL_MAX_CYC = `RSC_DWELL_MAX_CYC,
  parameter int CNT_W         = 14
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    unlock_ok,
  input  wire rsc_pkg::rsc_code_t [2:0] buck_setpoint_reg,
  input  wire logic [2:0]              setpoint_upd,
  output rsc_pkg::rsc_code_t [2:0]     buck_applied,
  output logic [2:0]                   ramp_busy,
  output logic                         force_pwm_buck_a,
  output logic                         force_pwm_buck_b,
  output logic                         force_pwm_buck_c,
  output rsc_pkg::rsc_lin_a_t          linear_a_level,
  output rsc_pkg::rsc_code_t           linear_b_level
);
  import rsc_pkg::*;

  // Refuse counter widths that the int arithmetic of these checks cannot express.
  if (CNT_W < 1 || CNT_W > 30)
  begin : g_cnt_w_bad
    $error("CNT_W is outside the supported range.");
  end

  // Refuse dwell settings that shift to zero at the fastest stepped code.
  if (DWELL_MAX_CYC < (1 << `RSC_SLEW_SHIFTS))
  begin : g_dwell_too_small
    $error("DWELL_MAX_CYC is too small for the fastest ramp code.");
  end

  // Refuse dwell settings that the dwell counter cannot hold.
  if (DWELL_MAX_CYC >= (1 << CNT_W))
  begin : g_dwell_too_large
    $error("DWELL_MAX_CYC does not fit the dwell counter.");
  end

  // Reset images of the three registers, kept whole so that fields can be picked out.
  localparam logic [7:0] RST_RAMP  = `RSC_RST_RAMP;
  localparam logic [7:0] RST_LIN_A = `RSC_RST_LIN_A;
  localparam logic [7:0] RST_LIN_B = `RSC_RST_LIN_B;

  // Register contents.
  logic       trigger_q;
  logic       trigger_bypass_q;
  logic [2:0] force_pwm_q;
  rsc_slew_t  slew_q;
  rsc_lin_a_t linear_a_q;
  logic       track_q;
  rsc_code_t  linear_b_q;
  rsc_code_t  linear_b_out_q;
  logic [31:0] prdata_q;
  logic       pslverr_q;

  // Bus decode.
  logic       setup;
  logic       access;
  logic       wr;
  logic       hit_ramp;
  logic       hit_lin_a;
  logic       hit_lin_b;
  logic       hit_status;
  logic       mapped;
  logic       prot_hit;
  logic       wr_ok;
  logic       go_pulse;
  logic [2:0] start;
  logic       any_busy;
  logic [7:0] ramp_rd;
  logic [7:0] lin_a_rd;
  logic [7:0] lin_b_rd;
  logic [7:0] stat_rd;
  logic [7:0] rd_byte;
  logic       bad_addr;
  logic       ro_write;
  logic       locked_write;

  rsc_ramp_if rif ();

  // The slave never inserts wait states, so every access phase lasts one cycle
  // and the master sees pready high at its first access edge.
  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign wr     = access && pwrite;

  // Address decode as one priority chain.
  always_comb
  begin
    hit_ramp   = 1'b0;
    hit_lin_a  = 1'b0;
    hit_lin_b  = 1'b0;
    hit_status = 1'b0;
    if (paddr == `RSC_ADDR_RAMP)
      hit_ramp = 1'b1;
    else if (paddr == `RSC_ADDR_LIN_A)
      hit_lin_a = 1'b1;
    else if (paddr == `RSC_ADDR_LIN_B)
      hit_lin_b = 1'b1;
    else if (paddr == `RSC_ADDR_STATUS)
      hit_status = 1'b1;
  end

  assign mapped   = hit_ramp || hit_lin_a || hit_lin_b || hit_status;
  assign prot_hit = hit_ramp || hit_lin_a || hit_lin_b;
  // Protected writes land only while the password logic reports unlock.
  // Unlock is looked at again on the access edge, so a lock in between still refuses.
  assign wr_ok    = wr && unlock_ok;

  // Error causes, judged in the setup cycle with the address and direction then shown.
  // A locked write is flagged here; wr_ok keeps the register itself unchanged.
  assign bad_addr     = !mapped;
  assign ro_write     = pwrite && hit_status;
  assign locked_write = pwrite && prot_hit && !unlock_ok;

  // A trigger write of one starts every channel; zero starts none.
  assign go_pulse = wr_ok && hit_ramp && pwdata[`RSC_BIT_GO];
  // In bypass, each setpoint update starts its own channel.
  // A start during a ramp retargets the channel and restarts the shared timer.
  assign start    = {3{go_pulse}} | (setpoint_upd & {3{trigger_bypass_q}});
  assign any_busy = |ramp_busy;

  // One timing setting and one timer serve all three converters.
  assign rif.slew_code = slew_q;
  assign rif.restart   = |start;

  rsc_step_timer #(
    .MAX_CYC (DWELL_MAX_CYC),
    .CNT_W   (CNT_W)
  ) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .tif     (rif)
  );

  // One ramp channel per buck converter.
  // Index 0 is the first converter and index 2 the third, which tracking reads.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_chan
      rsc_ramp_channel u_chan (
        .pclk     (pclk),
        .presetn  (presetn),
        .rif      (rif),
        .start    (start[gi]),
        .setpoint (buck_setpoint_reg[gi]),
        .applied  (buck_applied[gi]),
        .busy     (ramp_busy[gi])
      );
    end
  endgenerate

  // Trigger bit: a new trigger wins over the self-clear in the same cycle.
  // A zero written to the trigger bit never cuts a ramp in progress short.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      trigger_q <= 1'b0;
    else if (go_pulse)
      trigger_q <= 1'b1;
    else if (trigger_q && !any_busy)
      trigger_q <= 1'b0;
  end

  // Mode fields of the ramp register; bit 7 is kept by the trigger process.
  // Fields take effect at the access edge of an unlocked write.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trigger_bypass_q <= RST_RAMP[`RSC_BIT_BYPASS];
      force_pwm_q      <= RST_RAMP[`RSC_BIT_PWM_A:`RSC_BIT_PWM_C];
      slew_q           <= RST_RAMP[`RSC_SLEW_HI:`RSC_SLEW_LO];
    end
    else if (wr_ok && hit_ramp)
    begin
      trigger_bypass_q <= pwdata[`RSC_BIT_BYPASS];
      force_pwm_q      <= pwdata[`RSC_BIT_PWM_A:`RSC_BIT_PWM_C];
      slew_q           <= pwdata[`RSC_SLEW_HI:`RSC_SLEW_LO];
    end
  end

  // Force bits go straight to the converters.
  assign force_pwm_buck_a = force_pwm_q[2];
  assign force_pwm_buck_b = force_pwm_q[1];
  assign force_pwm_buck_c = force_pwm_q[0];

  // First linear regulator level; upper bits are not stored.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      linear_a_q <= RST_LIN_A[`RSC_LIN_A_HI:0];
    else if (wr_ok && hit_lin_a)
      linear_a_q <= pwdata[`RSC_LIN_A_HI:0];
  end

  // Level code goes out unchanged; the analog side maps it to volts.
  assign linear_a_level = linear_a_q;

  // Second linear regulator track bit and level.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      track_q    <= RST_LIN_B[`RSC_LIN_B_TRACK];
      linear_b_q <= RST_LIN_B[`RSC_LIN_B_HI:0];
    end
    else if (wr_ok && hit_lin_b)
    begin
      track_q    <= pwdata[`RSC_LIN_B_TRACK];
      linear_b_q <= pwdata[`RSC_LIN_B_HI:0];
    end
  end

  // Applied level: tracked or own code, clamped at RSC_LIN_B_CLAMP (6'h38).
  // Tracking reads the third setpoint register, not its ramped code, so it moves at once.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      linear_b_out_q <= RST_LIN_B[`RSC_LIN_B_HI:0];
    else if (track_q && buck_setpoint_reg[2] >= `RSC_LIN_B_CLAMP)
      linear_b_out_q <= `RSC_LIN_B_CLAMP;
    else if (track_q)
      linear_b_out_q <= buck_setpoint_reg[2];
    else if (linear_b_q >= `RSC_LIN_B_CLAMP)
      linear_b_out_q <= `RSC_LIN_B_CLAMP;
    else
      linear_b_out_q <= linear_b_q;
  end

  assign linear_b_level = linear_b_out_q;

  // Read views; reserved bits read zero.
  // Status mirrors trigger and per-converter busy so software can poll a ramp.
  assign ramp_rd  = {trigger_q, trigger_bypass_q, force_pwm_q, slew_q};
  assign lin_a_rd = {4'h0, linear_a_q};
  assign lin_b_rd = {1'b0, track_q, linear_b_q};
  assign stat_rd  = {4'h0, trigger_q, ramp_busy};

  // Read byte chosen by address; writes and unmapped addresses read zero.
  always_comb
  begin
    rd_byte = 8'h00;
    if (pwrite)
      rd_byte = 8'h00;
    else if (hit_ramp)
      rd_byte = ramp_rd;
    else if (hit_lin_a)
      rd_byte = lin_a_rd;
    else if (hit_lin_b)
      rd_byte = lin_b_rd;
    else if (hit_status)
      rd_byte = stat_rd;
  end

  // Read data is prepared in the setup cycle so it leaves a flip-flop.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h00000000;
    else if (setup)
      prdata_q <= {24'h000000, rd_byte};
  end

  // Error for unmapped addresses, status writes and locked protected writes.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr_q <= 1'b0;
    else if (setup)
      pslverr_q <= bad_addr || ro_write || locked_write;
  end
endmodule // rsc_regulator_ctrl

// [rsc_consts.svh]
// Offsets, field positions, reset values and timing counts of the ramp and regulator setting bank.
// Assumes a 50 MHz register clock and an APB bus with 8-bit byte addresses.
`ifndef RSC_CONSTS_SVH
`define RSC_CONSTS_SVH

// Register indices as printed; the byte address is four times the index.
`define RSC_IDX_RAMP      6'h11
`define RSC_IDX_LIN_A     6'h12
`define RSC_IDX_LIN_B     6'h13
`define RSC_IDX_STATUS    6'h14
`define RSC_ADDR_RAMP     {`RSC_IDX_RAMP, 2'b00}
`define RSC_ADDR_LIN_A    {`RSC_IDX_LIN_A, 2'b00}
`define RSC_ADDR_LIN_B    {`RSC_IDX_LIN_B, 2'b00}
`define RSC_ADDR_STATUS   {`RSC_IDX_STATUS, 2'b00}

// Reset values.
`define RSC_RST_RAMP      8'h06
`define RSC_RST_LIN_A     8'h09
`define RSC_RST_LIN_B     8'h38

// Field positions of the ramp and mode register.
`define RSC_BIT_GO        7
`define RSC_BIT_BYPASS    6
`define RSC_BIT_PWM_A     5
`define RSC_BIT_PWM_B     4
`define RSC_BIT_PWM_C     3
`define RSC_SLEW_HI       2
`define RSC_SLEW_LO       0
`define RSC_SLEW_IMMED    3'h7

// Field positions of the linear regulator registers.
`define RSC_LIN_A_HI      3
`define RSC_LIN_B_TRACK   6
`define RSC_LIN_B_HI      5
`define RSC_LIN_B_CLAMP   6'h38

// Field positions of the status register.
`define RSC_STAT_TRIG     3

// Ramp dwell times and their cycle counts at the register clock.
`define RSC_CLK_MHZ       50
`define RSC_DWELL_MAX_US  224
`define RSC_DWELL_MIN_NS  3500
`define RSC_DWELL_MAX_CYC (`RSC_DWELL_MAX_US * `RSC_CLK_MHZ)
`define RSC_DWELL_MIN_CYC ((`RSC_DWELL_MIN_NS * `RSC_CLK_MHZ + 999) / 1000)
`define RSC_SLEW_SHIFTS   6

`endif

// [rsc_pkg.sv]
// Types shared by the ramp and regulator setting bank.
// Assumes the constants header is compiled alongside.
package rsc_pkg;
  typedef logic [5:0] rsc_code_t;
  typedef logic [2:0] rsc_slew_t;
  typedef logic [3:0] rsc_lin_a_t;
endpackage

// [rsc_ramp_if.sv]
// Step timing signals passed from the dwell timer to the ramp channels.
// Assumes one timer driving all channels on the same clock.
`timescale 1ns/100ps
interface rsc_ramp_if;
  import rsc_pkg::*;
  rsc_slew_t slew_code;
  logic      restart;
  logic      step_tick;
  logic      immediate;

  modport ctrl  (output slew_code, output restart, input step_tick, input immediate);
  modport timer (input slew_code, input restart, output step_tick, output immediate);
  modport chan  (input step_tick, input immediate);
endinterface

// [rsc_step_timer.sv]
// Dwell timer that paces setpoint steps for all buck converters.
// Assumes restart pulses on every ramp start, on the register clock.
`timescale 1ns/100ps
`include "rsc_consts.svh"
module rsc_step_timer #(
  parameter int MAX_CYC = `RSC_DWELL_MAX_CYC,
  parameter int CNT_W   = 14
) (
  input wire logic pclk,
  input wire logic presetn,
  rsc_ramp_if.timer tif
);
  import rsc_pkg::*;

  localparam logic [CNT_W-1:0] MAX_C = CNT_W'(MAX_CYC);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] dwell;

  // Each higher slew code halves the dwell per step.
  always_comb
  begin
    dwell = MAX_C >> tif.slew_code;
  end

  assign tif.immediate = (tif.slew_code == `RSC_SLEW_IMMED);
  assign tif.step_tick = (cnt_q == dwell - CNT_W'(1));

  // Counter restarts with each ramp so the first step gets a full dwell.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= '0;
    else if (tif.restart || tif.step_tick || tif.immediate)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + CNT_W'(1);
  end
endmodule // rsc_step_timer

// [rsc_ramp_channel.sv]
// One buck converter's applied setpoint, stepped one code per dwell toward its target, or jumped there at the immediate slew code.
// Assumes start pulses for one cycle and setpoint is valid in that cycle.
`timescale 1ns/100ps
module rsc_ramp_channel (
  input  wire logic              pclk,
  input  wire logic              presetn,
  rsc_ramp_if.chan               rif,
  input  wire logic              start,
  input  wire rsc_pkg::rsc_code_t setpoint,
  output rsc_pkg::rsc_code_t     applied,
  output logic                   busy
);
  import rsc_pkg::*;

  rsc_code_t target_q;
  rsc_code_t applied_q;
  logic      init_q;

  assign applied = applied_q;
  assign busy    = (applied_q != target_q);

  // Target is latched when a ramp starts and in the first cycle after reset release.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      target_q <= '0;
    else if (start || !init_q)
      target_q <= setpoint;
  end

  // Applied code jumps or steps toward the target.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      applied_q <= '0;
    else if (!init_q)
      applied_q <= setpoint;              // Power-up takes the setpoint as is.
    else if (start && rif.immediate)
      applied_q <= setpoint;
    else if (!start && rif.immediate)
      applied_q <= target_q;
    else if (!start && rif.step_tick && applied_q < target_q)
      applied_q <= applied_q + 6'h01;
    else if (!start && rif.step_tick && applied_q > target_q)
      applied_q <= applied_q - 6'h01;
  end

  // Marks the first cycle after reset release.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      init_q <= 1'b0;
    else
      init_q <= 1'b1;
  end
endmodule // rsc_ramp_channel

// [rsc_regulator_ctrl_props.sv]
// Checker for the ramp and regulator setting bank, bound to its top module.
// Assumes single-cycle APB accesses and the byte addresses of the constants header.
`timescale 1ns/100ps
`include "rsc_consts.svh"
module rsc_regulator_ctrl_props (
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [7:0]               paddr,
  input wire logic [31:0]              pwdata,
  input wire logic [31:0]              prdata,
  input wire logic                     unlock_ok,
  input wire rsc_pkg::rsc_code_t [2:0] buck_applied,
  input wire logic [2:0]               ramp_busy,
  input wire logic                     force_pwm_buck_a,
  input wire logic                     force_pwm_buck_b,
  input wire logic                     force_pwm_buck_c,
  input wire rsc_pkg::rsc_lin_a_t      linear_a_level,
  input wire rsc_pkg::rsc_code_t       linear_b_level
);
  import rsc_pkg::*;
  logic       acc;
  logic [2:0] pwm;
  // Access-phase qualifier and the forced-mode outputs gathered in bit order.
  assign acc = psel && penable;
  assign pwm = {force_pwm_buck_a, force_pwm_buck_b, force_pwm_buck_c};
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // A span with no ramp and no write, then a read of the ramp register.
  sequence quiet_span;
    (ramp_busy == 3'h0 && !(psel && pwrite))[*3];
  endsequence
  sequence ramp_read;
    acc && !pwrite && paddr == `RSC_ADDR_RAMP;
  endsequence
  a_reset_vals: assert property ($rose(presetn) |-> pwm == 3'h0 && linear_a_level == 4'h9
    && linear_b_level == 6'h38) else $error("outputs differ from reset values");
  a_pwm_write: assert property (acc && pwrite && unlock_ok && paddr == `RSC_ADDR_RAMP
    |=> pwm == $past(pwdata[5:3])) else $error("forced mode outputs wrong after write");
  a_lin_a_write: assert property (acc && pwrite && unlock_ok && paddr == `RSC_ADDR_LIN_A
    |=> linear_a_level == $past(pwdata[3:0])) else $error("first linear level wrong");
  a_locked_hold: assert property (acc && pwrite && !unlock_ok
    |=> $stable(pwm) && $stable(linear_a_level)) else $error("locked write changed state");
  a_lin_a_resvd: assert property (acc && !pwrite && paddr == `RSC_ADDR_LIN_A
    |-> prdata[7:4] == 4'h0) else $error("first linear reserved bits not zero");
  a_lin_b_resvd: assert property (acc && !pwrite && paddr == `RSC_ADDR_LIN_B
    |-> prdata[7] == 1'b0) else $error("second linear reserved bit not zero");
  a_lin_b_clamp: assert property (acc && pwrite && unlock_ok && paddr == `RSC_ADDR_LIN_B
    && !pwdata[6] |=> ##1 linear_b_level == ($past(pwdata[5:0], 2) > 6'h38 ? 6'h38
    : $past(pwdata[5:0], 2))) else $error("second linear level not clamped");
  a_ramp_step: assert property (ramp_busy[0] && $past(ramp_busy[0])
    |-> 6'(buck_applied[0] - $past(buck_applied[0])) inside {6'h00, 6'h01, 6'h3F})
    else $error("ramp moved more than one code");
  a_trig_clear: assert property (quiet_span ##1 ramp_read |-> prdata[7] == 1'b0)
    else $error("trigger still set after ramps ended");
endmodule // rsc_regulator_ctrl_props

bind rsc_regulator_ctrl rsc_regulator_ctrl_props rsc_regulator_ctrl_props_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .unlock_ok,
  .buck_applied, .ramp_busy, .force_pwm_buck_a, .force_pwm_buck_b, .force_pwm_buck_c,
  .linear_a_level, .linear_b_level);

// [tb_regulator_setpoint_slew_ctrl.sv]
// Self-checking bench for the ramp and regulator setting bank.
// Assumes the checker file is compiled alongside and a shortened dwell of 64 cycles.
`timescale 1ns/100ps
`include "rsc_consts.svh"
module tb_regulator_setpoint_slew_ctrl;
  import rsc_pkg::*;
  localparam int         DW     = 64;
  localparam logic [7:0] A_RAMP = `RSC_ADDR_RAMP;
  localparam logic [7:0] A_LA   = `RSC_ADDR_LIN_A;
  localparam logic [7:0] A_LB   = `RSC_ADDR_LIN_B;
  localparam logic [7:0] A_ST   = `RSC_ADDR_STATUS;
  logic                pclk = 1'b0;
  logic                presetn = 1'b0;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic                unlock_ok = 1'b0;
  logic [7:0]          paddr = 8'h00;
  logic [31:0]         pwdata = 32'h0;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  rsc_code_t [2:0]     buck_setpoint_reg = {3{6'h08}};
  logic [2:0]          setpoint_upd = 3'h0;
  rsc_code_t [2:0]     buck_applied;
  logic [2:0]          ramp_busy;
  logic                force_pwm_buck_a;
  logic                force_pwm_buck_b;
  logic                force_pwm_buck_c;
  rsc_lin_a_t          linear_a_level;
  rsc_code_t           linear_b_level;
  logic [31:0]         q;
  logic                e;
  int                  n;
  int                  n_fail = 0;
  int                  samples_checked = 0;

  // Free-running 50 MHz clock.
  always #10 pclk = ~pclk;

  rsc_regulator_ctrl #(.DWELL_MAX_CYC(DW), .CNT_W(14)) rsc_regulator_ctrl_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .unlock_ok, .buck_setpoint_reg, .setpoint_upd, .buck_applied, .ramp_busy,
    .force_pwm_buck_a, .force_pwm_buck_b, .force_pwm_buck_c, .linear_a_level,
    .linear_b_level);

  // Counts one comparison and reports a difference at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Register write and read with their expected error flag.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    apb(1'b1, a, d);
    chk(e, ee, "write error flag");
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic ee);
    apb(1'b0, a, 32'h0);
    chk(q, x, "read data");
    chk(e, ee, "read error flag");
  endtask

  // Lets outputs settle after the given number of edges.
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask

  // Counts edges until the chosen converter leaves its present code.
  task automatic steps(input int c, output int k);
    rsc_code_t s;
    s = buck_applied[c];
    k = 0;
    while (buck_applied[c] === s && k < 300)
    begin
      @(posedge pclk);
      #1;
      k++;
    end
  endtask

  task automatic t_reset();
    rd(A_RAMP, 32'h06, 1'b0);
    rd(A_LA, 32'h09, 1'b0);
    rd(A_LB, 32'h38, 1'b0);
    chk({force_pwm_buck_a, force_pwm_buck_b, force_pwm_buck_c}, 3'h0, "pwm");
    $display("test reset done");
  endtask

  task automatic t_lock();
    wr(A_RAMP, 32'hBF, 1'b1);
    wr(A_LA, 32'h03, 1'b1);
    wr(A_LB, 32'h45, 1'b1);
    rd(A_RAMP, 32'h06, 1'b0);
    rd(A_LA, 32'h09, 1'b0);
    rd(A_LB, 32'h38, 1'b0);
    rd(8'h7C, 32'h00, 1'b1);
    wr(A_ST, 32'h0F, 1'b1);
    unlock_ok <= 1'b1;
    $display("test lock done");
  endtask

  task automatic t_linear();
    wr(A_LA, 32'hFF, 1'b0);
    rd(A_LA, 32'h0F, 1'b0);
    chk(linear_a_level, 4'hF, "linear a");
    wr(A_LA, 32'h00, 1'b0);
    buck_setpoint_reg[2] <= 6'h3C;
    cyc(1);
    chk(linear_a_level, 4'h0, "linear a");
    wr(A_LB, 32'hFF, 1'b0);
    rd(A_LB, 32'h7F, 1'b0);
    cyc(2);
    chk(linear_b_level, 6'h38, "track clamp");
    @(posedge pclk);
    buck_setpoint_reg[2] <= 6'h15;
    cyc(3);
    chk(linear_b_level, 6'h15, "track");
    wr(A_LB, 32'h3A, 1'b0);
    cyc(2);
    chk(linear_b_level, 6'h38, "clamp");
    wr(A_LB, 32'h21, 1'b0);
    cyc(2);
    chk(linear_b_level, 6'h21, "own level");
    @(posedge pclk);
    buck_setpoint_reg[2] <= 6'h08;
    $display("test linear done");
  endtask

  task automatic t_pwm();
    for (int i = 0; i < 3; i++)
    begin
      wr(A_RAMP, (32'h20 >> i) | 32'h07, 1'b0);
      cyc(1);
      chk({force_pwm_buck_a, force_pwm_buck_b, force_pwm_buck_c}, 3'h4 >> i, "pwm");
    end
    wr(A_RAMP, 32'h06, 1'b0);
    $display("test pwm done");
  endtask

  task automatic t_ramp();
    buck_setpoint_reg <= {3{6'h09}};
    wr(A_RAMP, 32'h80, 1'b0);
    rd(A_RAMP, 32'h80, 1'b0);
    rd(A_ST, 32'h0F, 1'b0);
    chk(ramp_busy, 3'h7, "busy");
    cyc(DW + 8);
    chk(buck_applied, {3{6'h09}}, "ramp end");
    chk(ramp_busy, 3'h0, "idle");
    rd(A_RAMP, 32'h00, 1'b0);
    rd(A_ST, 32'h00, 1'b0);
    // Every stepped code: one step timed from the trigger edge.
    for (int s = 0; s < 7; s++)
    begin
      @(posedge pclk);
      buck_setpoint_reg <= {3{6'(10 + s)}};
      wr(A_RAMP, 32'h80 | s, 1'b0);
      steps(0, n);
      chk(n, DW >> s, "dwell");
      chk(buck_applied, {3{6'(10 + s)}}, "all bucks");
    end
    @(posedge pclk);
    buck_setpoint_reg <= {3{6'h20}};
    wr(A_RAMP, 32'h06, 1'b0);
    cyc(10);
    chk(buck_applied, {3{6'h10}}, "no trigger");
    wr(A_RAMP, 32'h87, 1'b0);
    cyc(1);
    chk(buck_applied, {3{6'h20}}, "immediate");
    cyc(3);
    rd(A_RAMP, 32'h07, 1'b0);
    $display("test ramp done");
  endtask

  // Pulses the update strobe of one converter for a single edge.
  task automatic pulse(input logic [2:0] m);
    @(posedge pclk);
    setpoint_upd <= m;
    @(posedge pclk);
    setpoint_upd <= 3'h0;
  endtask

  task automatic t_bypass();
    wr(A_RAMP, 32'h01, 1'b0);
    buck_setpoint_reg[1] <= 6'h21;
    pulse(3'h2);
    cyc(40);
    chk(buck_applied[1], 6'h20, "no bypass");
    wr(A_RAMP, 32'h41, 1'b0);
    pulse(3'h2);
    steps(1, n);
    chk(n, DW >> 1, "bypass dwell");
    chk(buck_applied, {6'h20, 6'h21, 6'h20}, "bypass");
    $display("test bypass done");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Main sequence after six cycles of reset.
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_lock();
    t_linear();
    t_pwm();
    t_ramp();
    t_bypass();
    report_and_stop();
  end

  // Watchdog well beyond the expected few hundred cycles.
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    report_and_stop();
  end
endmodule // tb_regulator_setpoint_slew_ctrl
